// ===== rtl/srw_pkg.sv
// shared constants for the sleep, reset and watchdog controller
`default_nettype none
package srw_pkg;
    // ----------------------------------------------------------------
    // sleep mode encodings
    // ----------------------------------------------------------------
    localparam logic [2:0] MODE_IDLE = 3'h0;
    localparam logic [2:0] MODE_PDOWN = 3'h2;
    localparam logic [2:0] MODE_PSAVE = 3'h3;
    localparam logic [2:0] MODE_STDBY = 3'h6;
    localparam logic [2:0] MODE_ESTDBY = 3'h7;
    // ----------------------------------------------------------------
    // protected write targets and unlock
    // ----------------------------------------------------------------
    localparam logic [1:0] SEL_SWRST = 2'h0;
    localparam logic [1:0] SEL_WDCTRL = 2'h1;
    localparam logic [1:0] SEL_WDWIN = 2'h2;
    localparam logic [1:0] SEL_SIG = 2'h3;
    localparam logic [7:0] SIG_KEY = 8'hA5;
    localparam logic [2:0] UNLOCK_CYC = 3'h4;
    // ----------------------------------------------------------------
    // reset timing and cause bits
    // ----------------------------------------------------------------
    localparam logic [1:0] RST_PULSE = 2'h2;
    localparam logic [4:0] RST_HOLD = 5'h10;
    localparam int CAUSE_POR = 0;
    localparam int CAUSE_EXT = 1;
    localparam int CAUSE_BOD = 2;
    localparam int CAUSE_WD = 3;
    localparam int CAUSE_SW = 4;
    localparam logic [4:0] CAUSE_RST = 5'h01;
    // ----------------------------------------------------------------
    // watchdog: period p gives 8 << p ticks of 1 ms, p = 0..10
    // ----------------------------------------------------------------
    localparam logic [13:0] WD_BASE = 14'h0008;
    localparam logic [3:0] WD_PER_MAX = 4'hA;
    localparam logic [3:0] WD_PER_RST = 4'hA;
    localparam logic [15:0] BOOT_VEC = 16'h8000;
    localparam logic [15:0] APP_VEC = 16'h0000;
    // ----------------------------------------------------------------
    // apb register offsets and clock gate reset value
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CMD = 8'h04;
    localparam logic [7:0] OFS_PROT = 8'h08;
    localparam logic [7:0] OFS_PR = 8'h0C;
    localparam logic [7:0] OFS_STAT = 8'h10;
    localparam logic [5:0] GATE_ALL = 6'h3F;
endpackage
`default_nettype wire

// ===== rtl/srw_if.sv
// link between the cpu-side controller and the sleep/reset/watchdog unit
`default_nettype none
interface srw_if;
    logic sleep_req; // sleep instruction pulse
    logic [2:0] sleep_mode; // selected sleep mode
    logic sleep_en; // sleep enable
    logic wd_clear; // watchdog_clear_instruction pulse
    logic cause_clr; // clear reset cause pulse
    logic prot_wr; // protected write strobe
    logic [1:0] prot_sel; // protected target
    logic [7:0] prot_data; // protected data
    logic [7:0] pr_ctrl; // power reduction, one bit per peripheral
    logic asleep; // device sleeping
    logic [4:0] rst_cause; // latest reset source
    modport dev (input sleep_req, sleep_mode, sleep_en, wd_clear, cause_clr,
        prot_wr, prot_sel, prot_data, pr_ctrl, output asleep, rst_cause);
    modport host (output sleep_req, sleep_mode, sleep_en, wd_clear,
        cause_clr, prot_wr, prot_sel, prot_data, pr_ctrl,
        input asleep, rst_cause);
endinterface
`default_nettype wire

// ===== rtl/srw_dev.sv
// sleep, reset and watchdog_unit logic of the device end
//
// Chosen here: the APB slave port and the placing of the registers.
`default_nettype none
// How it works
// - five sleep modes, all entered from active
// - enabled interrupt or reset wakes to active
// - power reduction bit stops that peripheral clock
// - idle stops cpu and nvm clocks only
// - power-down stops all clock sources
// - power-down wakes on address match, port
// - power-save adds running rtc and wake
// - standby keeps clock sources, gates rest
// - extended standby keeps sources and rtc
// - reset loads registers, memory untouched
// - start at vector zero or boot
// - any reset tri-states pins, asynchronously
// - latest reset source kept for software
// - low external pin holds reset
// - brown-out when enabled, power-on always
// - watchdog expiry resets the device
// - software reset only after timed unlock
// - eleven periods 8 ms to 8 s
// - clear before timeout or reset
// - window mode clear inside limits only
// - watchdog changes need timed unlock
// - fuse keeps watchdog always on
module srw_dev
    import srw_pkg::*;
(
    input wire logic pclk, // system clock
    input wire logic presetn, // power-on reset, active low
    srw_if.dev s, // cpu-side link
    input wire logic por_low, // supply below power-on threshold
    input wire logic bod_en, // brown-out detector enabled
    input wire logic bod_low, // supply below brown-out threshold
    input wire logic ext_rst_n, // external reset pin, active low
    input wire logic periph_irq, // any enabled peripheral interrupt
    input wire logic twi_irq, // two_wire_address_match interrupt
    input wire logic port_irq, // asynchronous port interrupt
    input wire logic rtc_irq, // real-time counter interrupt
    input wire logic rtc_on, // real-time counter enabled
    input wire logic wd_tick, // 1 kHz tick of low_power_oscillator
    input wire logic wd_fuse_on, // always-on fuse programmed
    input wire logic boot_fuse, // reset vector moved to boot section
    output logic clk_cpu_en, // cpu clock gate
    output logic clk_nvm_en, // nonvolatile memory clock gate
    output logic clk_per_en, // peripheral clock gate
    output logic clk_rtc_en, // rtc clock gate
    output logic clk_src_en, // system clock sources run
    output logic clk_rtcsrc_en, // rtc clock source runs
    output logic [7:0] per_clk_en, // per-peripheral clock gates
    output logic sys_rst_n, // system reset, active low
    output logic io_tristate, // all pins tri-stated
    output logic [15:0] reset_vector // first fetch address
);
    // ----------------------------------------------------------------
    // functions
    // ----------------------------------------------------------------
    // gates: {cpu, nvm, per, rtc, src, rtcsrc}
    function automatic logic [5:0] gates(input logic slp,
        input logic [2:0] m, input logic rtc);
        logic [5:0] g;
        g = GATE_ALL;
        if (slp)
        begin
            case (m)
                MODE_IDLE: g = 6'h0F;
                MODE_PDOWN: g = 6'h00;
                MODE_PSAVE: g = {3'h0, rtc, 1'b0, rtc};
                MODE_STDBY: g = 6'h02;
                MODE_ESTDBY: g = {3'h0, rtc, 1'b1, rtc};
                default: g = GATE_ALL;
            endcase
        end
        return g;
    endfunction

    // watchdog limit in ticks for a period code
    function automatic logic [13:0] wd_limit(input logic [3:0] p);
        return WD_BASE << p;
    endfunction

    // clamp an out-of-range period code to the longest period
    function automatic logic [3:0] clamp(input logic [3:0] p);
        return (p > WD_PER_MAX) ? WD_PER_MAX : p;
    endfunction

    // ----------------------------------------------------------------
    // reset tree
    // ----------------------------------------------------------------
    typedef enum logic {ST_ACTIVE = 1'b0, ST_SLEEP = 1'b1} srw_slp_t;
    logic int_fire; // watchdog or software reset in progress
    logic [1:0] fire_cnt; // length of the internal pulse
    logic [4:0] hold_cnt; // reset stretch after release
    logic [4:0] cause; // latest reset cause
    wire ext_src = por_low | (bod_en & bod_low) | ~ext_rst_n;
    // any source drops every register below, save the power-on domain, without a clock
    wire rst_n_async = presetn & ~ext_src & ~int_fire;

    logic [2:0] unlock_cnt; // open cycles of the unlock window
    logic wd_en; // software watchdog enable
    logic [3:0] wd_per; // timeout period code
    logic win_en; // window mode enabled
    logic [3:0] win_per; // closed window period code
    logic [13:0] wd_cnt; // ticks since last clear
    srw_slp_t state; // sleep state
    logic [2:0] mode; // mode latched at sleep entry

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    wire unlocked = unlock_cnt != 3'h0;
    wire sig_hit = s.prot_wr & (s.prot_sel == SEL_SIG)
        & (s.prot_data == SIG_KEY);
    wire prot_ok = s.prot_wr & (s.prot_sel != SEL_SIG) & unlocked;
    wire sw_hit = prot_ok & (s.prot_sel == SEL_SWRST) & s.prot_data[0];
    wire wdc_wr = prot_ok & (s.prot_sel == SEL_WDCTRL);
    wire wdw_wr = prot_ok & (s.prot_sel == SEL_WDWIN);
    wire wd_on = wd_en | wd_fuse_on;
    wire wd_late = wd_on & (wd_cnt >= wd_limit(wd_per));
    wire wd_early = wd_on & win_en & s.wd_clear
        & (wd_cnt < wd_limit(win_per));
    wire wd_expire = wd_late | wd_early;
    wire [4:0] src_bits = {sw_hit, wd_expire, bod_en & bod_low,
        ~ext_rst_n, por_low};
    wire mode_ok = (s.sleep_mode == MODE_IDLE)
        | (s.sleep_mode == MODE_PDOWN) | (s.sleep_mode == MODE_PSAVE)
        | (s.sleep_mode == MODE_STDBY) | (s.sleep_mode == MODE_ESTDBY);
    wire sleep_go = (state == ST_ACTIVE) & s.sleep_req & s.sleep_en
        & mode_ok;
    wire async_wake = twi_irq | port_irq;
    wire rtc_wake = rtc_on & rtc_irq;
    wire wake = (mode == MODE_IDLE) ? (periph_irq | async_wake | rtc_wake)
        : ((mode == MODE_PSAVE) | (mode == MODE_ESTDBY))
        ? (async_wake | rtc_wake) : async_wake;
    wire [2:0] next_mode = sleep_go ? s.sleep_mode : mode;
    srw_slp_t next_state;
    assign next_state = sleep_go ? ST_SLEEP
        : ((state == ST_SLEEP) & wake) ? ST_ACTIVE : state;
    wire [5:0] next_gate = gates(next_state == ST_SLEEP, next_mode, rtc_on);

    // ----------------------------------------------------------------
    // internal reset pulse and cause record (power-on domain)
    // ----------------------------------------------------------------
    // the pulse lives outside the domain it resets, so it is not
    // cut short by its own effect
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            int_fire <= 1'b0;
            fire_cnt <= 2'h0;
        end
        else if (wd_expire | sw_hit)
        begin
            int_fire <= 1'b1;
            fire_cnt <= RST_PULSE;
        end
        else if (fire_cnt != 2'h0)
            fire_cnt <= fire_cnt - 2'h1;
        else
            int_fire <= 1'b0;
    end

    // a new source replaces the record and beats a clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cause <= CAUSE_RST;
        else if (src_bits != 5'h00)
            cause <= src_bits;
        else if (s.cause_clr)
            cause <= 5'h00;
    end
    assign s.rst_cause = cause;

    // ----------------------------------------------------------------
    // reset release, pin tri-state and vector
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge rst_n_async)
    begin
        if (!rst_n_async)
        begin
            hold_cnt <= 5'h00;
            sys_rst_n <= 1'b0;
            io_tristate <= 1'b1;
            reset_vector <= APP_VEC;
        end
        else
        begin
            if (hold_cnt != RST_HOLD)
                hold_cnt <= hold_cnt + 5'h01;
            sys_rst_n <= hold_cnt == RST_HOLD;
            io_tristate <= hold_cnt != RST_HOLD;
            // fuse read by the clock after release, not by the reset
            reset_vector <= boot_fuse ? BOOT_VEC : APP_VEC;
        end
    end

    // ----------------------------------------------------------------
    // timed unlock window
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge rst_n_async)
    begin
        if (!rst_n_async)
            unlock_cnt <= 3'h0;
        else if (sig_hit)
            unlock_cnt <= UNLOCK_CYC;
        else if (prot_ok)
            unlock_cnt <= 3'h0; // one write per unlock
        else if (unlocked)
            unlock_cnt <= unlock_cnt - 3'h1;
    end

    // ----------------------------------------------------------------
    // watchdog configuration and counter
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge rst_n_async)
    begin
        if (!rst_n_async)
        begin
            wd_en <= 1'b0;
            wd_per <= WD_PER_RST;
            win_en <= 1'b0;
            win_per <= 4'h0;
        end
        else if (wdc_wr)
        begin
            wd_en <= s.prot_data[0]; // fuse overrides a disable
            wd_per <= clamp(s.prot_data[4:1]);
        end
        else if (wdw_wr)
        begin
            win_en <= s.prot_data[0];
            win_per <= clamp(s.prot_data[4:1]);
        end
    end

    // saturating tick counter, restarted by any clear or change
    always_ff @(posedge pclk or negedge rst_n_async)
    begin
        if (!rst_n_async)
            wd_cnt <= 14'h0000;
        else if (!wd_on | s.wd_clear | wdc_wr | wdw_wr)
            wd_cnt <= 14'h0000;
        else if (wd_tick & (wd_cnt != 14'h3FFF))
            wd_cnt <= wd_cnt + 14'h0001;
    end

    // ----------------------------------------------------------------
    // sleep state and clock gates
    // ----------------------------------------------------------------
    // outputs are loaded from next values so gates follow the state
    always_ff @(posedge pclk or negedge rst_n_async)
    begin
        if (!rst_n_async)
        begin
            state <= ST_ACTIVE;
            mode <= MODE_IDLE;
            {clk_cpu_en, clk_nvm_en, clk_per_en} <= 3'h7;
            {clk_rtc_en, clk_src_en, clk_rtcsrc_en} <= 3'h7;
            per_clk_en <= 8'hFF;
        end
        else
        begin
            state <= next_state;
            mode <= next_mode;
            {clk_cpu_en, clk_nvm_en, clk_per_en} <= next_gate[5:3];
            {clk_rtc_en, clk_src_en, clk_rtcsrc_en} <= next_gate[2:0];
            per_clk_en <= {8{next_gate[3]}} & ~s.pr_ctrl;
        end
    end
    assign s.asleep = state == ST_SLEEP;
endmodule // srw_dev
`default_nettype wire

// ===== rtl/srw_host.sv
// cpu-side controller: apb registers driving the sleep/reset link
`default_nettype none
module srw_host
    import srw_pkg::*;
(
    input wire logic pclk, // system clock
    input wire logic presetn, // reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped address
    srw_if.host m // device link
);
    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {P_IDLE = 2'b00, P_SIG = 2'b01,
        P_DATA = 2'b11} srw_prot_t;
    srw_prot_t pst; // protected write sequencer
    logic [1:0] q_sel; // queued target
    logic [7:0] q_data; // queued data
    logic [3:0] ctrl; // {sleep_en, mode}
    wire acc = psel & penable & pready;
    wire wr = acc & pwrite;
    wire is_prot = paddr == OFS_PROT;
    wire mapped = (paddr == OFS_CTRL) | (paddr == OFS_CMD) | is_prot
        | (paddr == OFS_PR) | (paddr == OFS_STAT);
    // a protected write waits while the sequencer is busy
    wire stall = pwrite & is_prot & (pst != P_IDLE);
    wire next_pready = psel & penable & ~pready & ~stall;
    wire launch = wr & is_prot & (pwdata[9:8] != SEL_SIG);
    wire cmd_wr = wr & (paddr == OFS_CMD);
    wire [31:0] rd_val = (paddr == OFS_CTRL) ? {28'h0, ctrl}
        : (paddr == OFS_PR) ? {24'h0, m.pr_ctrl}
        : (paddr == OFS_STAT) ? {24'h0, pst != P_IDLE, m.asleep, 1'b0,
        m.rst_cause} : 32'h0;
    srw_prot_t next_pst;
    assign next_pst = (pst == P_SIG) ? P_DATA
        : launch ? P_SIG : P_IDLE;

    // ----------------------------------------------------------------
    // apb answer
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end
        else
        begin
            pready <= next_pready;
            pslverr <= next_pready & ~mapped;
            prdata <= (next_pready & ~pwrite) ? rd_val : 32'h0;
        end
    end

    // ----------------------------------------------------------------
    // registers and command pulses
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl <= 4'h0;
            m.pr_ctrl <= 8'h00;
            m.sleep_req <= 1'b0;
            m.wd_clear <= 1'b0;
            m.cause_clr <= 1'b0;
        end
        else
        begin
            if (wr & (paddr == OFS_CTRL))
                ctrl <= pwdata[3:0];
            if (wr & (paddr == OFS_PR))
                m.pr_ctrl <= pwdata[7:0];
            // sleep is only issued with the enable set
            m.sleep_req <= cmd_wr & pwdata[0] & ctrl[3];
            m.wd_clear <= cmd_wr & pwdata[1];
            m.cause_clr <= cmd_wr & pwdata[2];
        end
    end
    assign m.sleep_mode = ctrl[2:0];
    assign m.sleep_en = ctrl[3];

    // ----------------------------------------------------------------
    // protected write sequence: signature, then data next cycle
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pst <= P_IDLE;
            q_sel <= SEL_SWRST;
            q_data <= 8'h00;
            m.prot_wr <= 1'b0;
            m.prot_sel <= SEL_SIG;
            m.prot_data <= 8'h00;
        end
        else
        begin
            pst <= next_pst;
            if (launch)
            begin
                q_sel <= pwdata[9:8];
                q_data <= pwdata[7:0];
            end
            m.prot_wr <= next_pst != P_IDLE;
            m.prot_sel <= (next_pst == P_DATA) ? q_sel : SEL_SIG;
            m.prot_data <= (next_pst == P_DATA) ? q_data : SIG_KEY;
        end
    end
endmodule // srw_host
`default_nettype wire

// ===== testbench/srw_monitor.sv
// link checker for the controller and device ends
`default_nettype none
module srw_monitor
    import srw_pkg::*;
(
    input wire logic pclk, // clock
    input wire logic presetn, // reset, low
    input wire logic sleep_req, // sleep pulse
    input wire logic [2:0] sleep_mode, // mode
    input wire logic sleep_en, // sleep enable
    input wire logic wd_clear, // clear pulse
    input wire logic cause_clr, // cause clear
    input wire logic prot_wr, // protected strobe
    input wire logic [1:0] prot_sel, // target
    input wire logic [7:0] prot_data, // data
    input wire logic asleep, // sleeping
    input wire logic [4:0] rst_cause // cause record
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // decoded helpers
    wire logic mode_ok = sleep_mode inside {MODE_IDLE, MODE_PDOWN,
        MODE_PSAVE, MODE_STDBY, MODE_ESTDBY};
    wire logic sig_wr = prot_wr && (prot_sel == SEL_SIG);
    wire logic sw_wr = prot_wr && (prot_sel == SEL_SWRST) && prot_data[0];
    // ------------
    // assertions
    // ------------
    AST_SLEEP_ENTER: assert property (sleep_req && mode_ok &&
        !asleep |=> asleep) else $error("sleep not entered");
    AST_SLEEP_REFUSE: assert property (sleep_req |-> sleep_en)
        else $error("sleep without enable");
    AST_SLEEP_CAUSE: assert property ($rose(asleep) |->
        $past(sleep_req) && $past(sleep_en)) else $error("stray sleep");
    AST_REQ_PULSE: assert property (sleep_req |=> !sleep_req)
        else $error("sleep request too long");
    AST_CLEAR_PULSE: assert property (wd_clear |=> !wd_clear)
        else $error("clear pulse too long");
    AST_SIG_THEN_DATA: assert property (sig_wr |->
        prot_data == SIG_KEY ##1 (prot_wr && !sig_wr)) else $error("bad key");
    AST_DATA_NEEDS_SIG: assert property (prot_wr && !sig_wr
        |-> $past(sig_wr)) else $error("write without signature");
    AST_CAUSE_POR: assert property ($rose(presetn) |->
        rst_cause == CAUSE_RST) else $error("cause after power-on");
    AST_CAUSE_CLR: assert property (cause_clr |=> rst_cause == 5'h00)
        else $error("cause not cleared");
    AST_SW_CAUSE: assert property (sw_wr && $past(sig_wr) |->
        ##[1:8] rst_cause[CAUSE_SW]) else $error("software cause missing");
    // main scenarios seen
    cover property (sleep_req && sleep_en);
    cover property (sig_wr);
    cover property (cause_clr);
endmodule // srw_monitor
`default_nettype wire

// ===== testbench/tb_top.sv
// bench for the apb controller joined to the device end
`default_nettype none
module tb_top
    import srw_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk, presetn, psel, penable, pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic pready, pslverr, e, por_low, bod_en, bod_low, ext_rst_n;
    logic periph_irq, twi_irq, port_irq, rtc_irq, rtc_on;
    logic wd_tick, wd_fuse_on, boot_fuse;
    logic c_cpu, c_nvm, c_per, c_rtc, c_src, c_rsrc, sys_rst_n, io_tristate;
    logic [7:0] per_clk_en;
    logic [15:0] reset_vector;
    wire logic [5:0] gates = {c_cpu, c_nvm, c_per, c_rtc, c_src, c_rsrc};
    int mismatches = 0, checks_done = 0, cyc = 0;
    // expected gate pattern per mode, rtc enabled
    logic [2:0] md [5] = '{MODE_IDLE, MODE_PDOWN, MODE_PSAVE, MODE_STDBY,
        MODE_ESTDBY};
    logic [5:0] ge [5] = '{6'h0F, 6'h00, 6'h05, 6'h02, 6'h07};
    logic [3:0] src [3] = '{4'h0, 4'h7, 4'h9}; // ext, brown-out, power-on
    logic [4:0] ce [3] = '{5'h02, 5'h04, 5'h01};
    srw_if srw_if_i ();
    srw_host srw_host_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .m(srw_if_i));
    srw_dev srw_dev_i (.pclk, .presetn, .s(srw_if_i), .por_low, .bod_en,
        .bod_low, .ext_rst_n, .periph_irq, .twi_irq, .port_irq, .rtc_irq,
        .rtc_on, .wd_tick, .wd_fuse_on, .boot_fuse, .clk_cpu_en(c_cpu),
        .clk_nvm_en(c_nvm), .clk_per_en(c_per), .clk_rtc_en(c_rtc),
        .clk_src_en(c_src), .clk_rtcsrc_en(c_rsrc), .per_clk_en, .sys_rst_n,
        .io_tristate, .reset_vector);
    srw_monitor srw_monitor_i (.pclk, .presetn,
        .sleep_req(srw_if_i.sleep_req), .sleep_mode(srw_if_i.sleep_mode),
        .sleep_en(srw_if_i.sleep_en), .wd_clear(srw_if_i.wd_clear),
        .cause_clr(srw_if_i.cause_clr), .prot_wr(srw_if_i.prot_wr),
        .prot_sel(srw_if_i.prot_sel), .prot_data(srw_if_i.prot_data),
        .asleep(srw_if_i.asleep), .rst_cause(srw_if_i.rst_cause));
    // ------------
    // helpers
    // ------------
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] s, x);
        checks_done++;
        if (s !== x)
        begin
            mismatches++;
            $display("MISMATCH %s exp %h seen %h", nm, x, s);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // one apb transfer; an idle edge after it keeps psel single-driven
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] rq, output logic re);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rq = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, q, e);
    endtask
    task automatic rdc(input string nm, input logic [7:0] a,
        input logic [31:0] x);
        apb(1'b0, a, '0, q, e);
        chk(nm, q, x);
    endtask
    // wait out the stretched device reset
    task automatic recover();
        int n = 0;
        while (sys_rst_n !== 1'b1 && n < 100)
        begin
            @(posedge pclk);
            n++;
        end
        chk("recover", sys_rst_n, 1'b1);
        tick(2);
    endtask
    task automatic ticks(input int n);
        repeat (n)
        begin
            wd_tick <= 1'b1;
            @(posedge pclk);
            wd_tick <= 1'b0;
            @(posedge pclk);
        end
    endtask
    // ------------
    // clock, timeout and tests
    // ------------
    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    // runaway guard, well above the few hundred cycles needed
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            mismatches++;
            results();
        end
    end
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata, wd_tick, boot_fuse} = '0;
        {por_low, bod_en, bod_low, periph_irq, twi_irq, port_irq} = '0;
        {rtc_irq, wd_fuse_on, ext_rst_n, rtc_on, presetn} = 5'h06;
        tick(12);
        presetn <= 1'b1;
        tick(20);
        chk("pins", {io_tristate, sys_rst_n}, 2'h1);
        chk("vector", reset_vector, APP_VEC);
        chk("gates", {per_clk_en, gates}, 14'h3FFF);
        rdc("cause", OFS_STAT, 32'h01);
        apb(1'b0, 8'h40, '0, q, e);
        chk("unmapped", {e, q[30:0]}, 32'h80000000);
        wr(OFS_CMD, 32'h4);
        rdc("cleared", OFS_STAT, 32'h00);
        wr(OFS_PR, 32'h5A);
        tick(3);
        chk("reduction", per_clk_en, 8'hA5);
        wr(OFS_CTRL, 32'h2);
        wr(OFS_CMD, 32'h1);
        tick(3);
        chk("no enable", srw_if_i.asleep, 1'b0);
        $display("test reset and registers done");
        for (int i = 0; i < 5; i++)
        begin
            wr(OFS_CTRL, {28'h0, 1'b1, md[i]});
            wr(OFS_CMD, 32'h1);
            tick(3);
            chk("sleep", {srw_if_i.asleep, gates},
                {1'b1, ge[i]});
            if (i != 0)
            begin
                {periph_irq, rtc_irq} <= {1'b1, i[0]};
                tick(4);
                chk("no wake", srw_if_i.asleep, 1'b1);
            end
            periph_irq <= (i == 0);
            twi_irq <= (i == 1);
            port_irq <= (i == 3);
            rtc_irq <= (i == 2 || i == 4);
            tick(4);
            chk("wake", {srw_if_i.asleep, gates}, 7'h3F);
            {periph_irq, twi_irq, port_irq, rtc_irq} <= 4'h0;
            tick(2);
        end
        $display("test sleep modes done");
        bod_low <= 1'b1;
        tick(4);
        chk("bod off", sys_rst_n, 1'b1);
        for (int i = 0; i < 3; i++)
        begin
            {por_low, bod_en, bod_low, ext_rst_n} <= src[i];
            #1;
            chk("async", {io_tristate, sys_rst_n}, 2'h2);
            tick(3);
            {por_low, bod_en, bod_low, ext_rst_n} <= 4'h1;
            recover();
            rdc("source", OFS_STAT, {27'h0, ce[i]});
        end
        wr(OFS_PROT, 32'h001);
        tick(3);
        chk("software", {io_tristate, sys_rst_n}, 2'h2);
        recover();
        rdc("sw cause", OFS_STAT, 32'h10);
        $display("test reset sources done");
        boot_fuse <= 1'b1;
        wr(OFS_PROT, {22'h0, SEL_WDCTRL, 8'h01});
        tick(3);
        ticks(7);
        wr(OFS_CMD, 32'h2);
        tick(3);
        ticks(7);
        chk("wd alive", sys_rst_n, 1'b1);
        ticks(1);
        tick(3);
        chk("wd fire", sys_rst_n, 1'b0);
        recover();
        rdc("wd cause", OFS_STAT, 32'h08);
        chk("boot", reset_vector, BOOT_VEC);
        wd_fuse_on <= 1'b1;
        wr(OFS_PROT, {22'h0, SEL_WDWIN, 8'h01});
        wr(OFS_PROT, {22'h0, SEL_WDCTRL, 8'h02});
        tick(3);
        ticks(3);
        wr(OFS_CMD, 32'h2);
        tick(3);
        chk("early clear", sys_rst_n, 1'b0);
        recover();
        $display("test watchdog done");
        results();
    end
endmodule // tb_top
`default_nettype wire
